// [pkg/dtfm_cfg.svh]
`ifndef DTFM_CFG_SVH
`define DTFM_CFG_SVH

// register byte offsets
`define DTFM_OFS_IN_FUNC   8'h00
`define DTFM_OFS_OUT_FUNC  8'h20
`define DTFM_OFS_CTRL      8'h40
`define DTFM_OFS_SPD_THR   8'h44
`define DTFM_OFS_STATE     8'h48
`define DTFM_OFS_INT_STAT  8'h4C
`define DTFM_OFS_INT_MASK  8'h50

// field positions
`define DTFM_IN_CODE_W     6
`define DTFM_OUT_CODE_W    4
`define DTFM_POL_BIT       8
`define DTFM_CTRL_XIE_BIT  0

// reset values
`define DTFM_IN_CODE_RST   6'h3F
`define DTFM_IN_POL_RST    1'b1
`define DTFM_OUT1_CODE_RST 4'h0
`define DTFM_OUT2_CODE_RST 4'h1
`define DTFM_OUT3_CODE_RST 4'h3
`define DTFM_OUT4_CODE_RST 4'h4
`define DTFM_ALM_CODE_RST  4'h6
`define DTFM_OUT_POL_RST   1'b1
`define DTFM_SPD_THR_RST   16'h0014

// function codes
`define DTFM_FN_HOLD       19
`define DTFM_FN_STORED     20
`define DTFM_FN_HOME       21
`define DTFM_FN_ORIGIN     22
`define DTFM_FN_FIRST      19
`define DTFM_FN_LAST       33
`define DTFM_FN_XTRIG      29
`define DTFM_FN_XREARM     30

`endif

// [pkg/dtfm_pkg.sv]
package dtfm_pkg;

    typedef struct packed {
        logic        ready;
        logic        energised;
        logic [15:0] speed;
        logic        speed_reached;
        logic        position_done;
        logic        torque_limited;
        logic        fault;
        logic        brake;
        logic        overload_warn;
        logic        speed_limited;
        logic        stored_move_active;
        logic        deviation_excess;
        logic        homing_done;
        logic        cam_active;
    } dtfm_status_t;

    typedef struct packed {
        logic hold_position;
        logic stored_move_trigger;
        logic home_search_trigger;
        logic origin_marker;
        logic analog_speed_fwd;
        logic analog_speed_rev;
        logic mode_switch;
        logic jog_forward;
        logic jog_reverse;
        logic motor_overheat;
        logic gantry_sync_start;
        logic cam_enable;
        logic cam_select;
    } dtfm_cmd_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } dtfm_avm_req_t;

endpackage

// [hw/dtfm_terminal_map.sv]
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "dtfm_cfg.svh"
module dtfm_terminal_map #(
    parameter int N_IN  = 8,
    parameter int N_OUT = 4
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       ce,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [7:0]                 avs_address,
    input  wire logic [31:0]                avs_writedata,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic [N_IN-1:0]            terminal_pin,
    input  wire logic                       power_up_latch,
    input  wire dtfm_pkg::dtfm_status_t     drive_status,
    output dtfm_pkg::dtfm_cmd_t             drive_cmd,
    output logic [N_OUT-1:0]                general_output,
    output logic                            alarm_output,
    output logic                            irq
);
    import dtfm_pkg::*;

    localparam int NO   = N_OUT + 1;
    localparam int CW   = `DTFM_IN_CODE_W;
    localparam int OW   = `DTFM_OUT_CODE_W;
    localparam int NEV  = 5;

    if (N_IN < 1 || N_IN > 8 || N_OUT != 4) begin : g_bad_params
        $error("dtfm_terminal_map: N_IN must be 1..8 and N_OUT 4");
    end

    // pending settings written by software, active ones used by the logic
    logic [CW-1:0] pend_in_code [N_IN];
    logic [N_IN-1:0] pend_in_pol;
    logic [OW-1:0] pend_out_code [NO];
    logic [NO-1:0] pend_out_pol;
    logic [CW-1:0] act_in_code [N_IN];
    logic [N_IN-1:0] act_in_pol;
    logic [OW-1:0] act_out_code [NO];
    logic [NO-1:0] act_out_pol;
    logic          xint_en;
    logic [15:0]   spd_thr;
    logic [NEV-1:0] int_stat;
    logic [NEV-1:0] int_mask;
    logic          ack;
    logic [31:0]   rdata;

    logic [CW-1:0] next_pend_in_code [N_IN];
    logic [N_IN-1:0] next_pend_in_pol;
    logic [OW-1:0] next_pend_out_code [NO];
    logic [NO-1:0] next_pend_out_pol;
    logic [CW-1:0] next_act_in_code [N_IN];
    logic [N_IN-1:0] next_act_in_pol;
    logic [OW-1:0] next_act_out_code [NO];
    logic [NO-1:0] next_act_out_pol;
    logic          next_xint_en;
    logic [15:0]   next_spd_thr;
    logic [NEV-1:0] next_int_stat;
    logic [NEV-1:0] next_int_mask;
    logic          next_ack;
    logic [31:0]   next_rdata;

    // terminal path state
    logic [N_IN-1:0] sync1, sync2, sync3, filt;
    logic [N_IN-1:0] next_sync1, next_sync2, next_sync3, next_filt;
    logic [`DTFM_FN_LAST:`DTFM_FN_FIRST] lvl, lvl_prev, next_lvl_prev;
    logic            armed, next_armed;
    logic            fault_prev, next_fault_prev;
    dtfm_cmd_t       next_cmd;
    logic [NO-1:0]   outs, next_outs;

    logic [N_IN-1:0] term_act;
    logic [`DTFM_FN_LAST:`DTFM_FN_FIRST] rise;
    logic [15:0]     spd_abs;
    logic [15:0]     st;
    logic            xtrig_ok;
    logic [NEV-1:0]  ev;
    logic            req;
    logic            wr_go;
    logic [7:0]      ofs;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign wr_go           = ce & avs_write & ack;
    assign ofs             = avs_address;

    // input conditioning
    always_comb begin
        next_sync1 = terminal_pin;
        next_sync2 = sync1;
        next_sync3 = sync2;
        // a change counts once stages two and three agree
        next_filt  = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            filt  <= '0;
        end else if (ce) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sync3 <= next_sync3;
            filt  <= next_filt;
        end
    end

    // pin high taken as switch closed when the polarity bit is 1, pin low when it is 0
    assign term_act = ~(act_in_pol ^ filt);

    always_comb begin
        lvl = '0;
        for (int c = `DTFM_FN_FIRST; c <= `DTFM_FN_LAST; c++) begin
            for (int i = 0; i < N_IN; i++) begin
                if (act_in_code[i] == CW'(c) && term_act[i]) begin
                    lvl[c] = 1'b1;
                end
            end
        end
    end

    assign rise     = lvl & ~lvl_prev;
    assign xtrig_ok = rise[`DTFM_FN_XTRIG] & xint_en & armed;

    // motion command path
    always_comb begin
        next_lvl_prev   = lvl;
        next_fault_prev = drive_status.fault;
        next_armed      = armed;
        if (xtrig_ok) begin
            next_armed = 1'b0;
        end
        // re-arm wins over a trigger in the same cycle
        if (rise[`DTFM_FN_XREARM]) begin
            next_armed = 1'b1;
        end
        next_cmd.hold_position       = lvl[`DTFM_FN_HOLD];
        next_cmd.stored_move_trigger = rise[`DTFM_FN_STORED] | xtrig_ok;
        next_cmd.home_search_trigger = rise[`DTFM_FN_HOME];
        next_cmd.origin_marker       = rise[`DTFM_FN_ORIGIN];
        next_cmd.analog_speed_fwd    = lvl[23];
        next_cmd.analog_speed_rev    = lvl[24];
        next_cmd.mode_switch         = lvl[25];
        next_cmd.jog_forward         = lvl[26];
        next_cmd.jog_reverse         = lvl[27];
        next_cmd.motor_overheat      = lvl[28];
        next_cmd.gantry_sync_start   = lvl[31];
        next_cmd.cam_enable          = lvl[32];
        next_cmd.cam_select          = lvl[33];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lvl_prev   <= '0;
            fault_prev <= 1'b0;
            armed      <= 1'b1;
            drive_cmd  <= '0;
        end else if (ce) begin
            lvl_prev   <= next_lvl_prev;
            fault_prev <= next_fault_prev;
            armed      <= next_armed;
            drive_cmd  <= next_cmd;
        end
    end

    // status selection
    assign spd_abs = drive_status.speed[15] ? 16'(-drive_status.speed) : drive_status.speed;

    always_comb begin
        st     = '0;
        st[0]  = drive_status.ready & ~drive_status.fault;
        st[1]  = drive_status.energised;
        st[2]  = spd_abs > spd_thr;
        st[3]  = drive_status.speed_reached;
        st[4]  = drive_status.position_done;
        st[5]  = drive_status.torque_limited;
        st[6]  = drive_status.fault;
        st[7]  = drive_status.brake;
        st[8]  = drive_status.overload_warn;
        st[9]  = drive_status.speed_limited;
        st[10] = drive_status.stored_move_active;
        st[11] = drive_status.deviation_excess;
        st[12] = drive_status.homing_done;
        st[13] = 1'b0;
        st[14] = drive_status.cam_active;
    end

    for (genvar k = 0; k < NO; k++) begin : g_out
        // contact type 1 drives high when the function is true
        assign next_outs[k] = ~(st[act_out_code[k]] ^ act_out_pol[k]);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            outs <= '0;
        end else if (ce) begin
            outs <= next_outs;
        end
    end

    assign general_output = outs[N_OUT-1:0];
    assign alarm_output   = outs[N_OUT];

    // events and interrupt
    assign ev = {drive_status.fault & ~fault_prev, xtrig_ok, rise[`DTFM_FN_ORIGIN],
                 rise[`DTFM_FN_HOME], rise[`DTFM_FN_STORED]};
    assign irq = |(int_stat & int_mask);

    // register bank
    always_comb begin
        next_pend_in_code  = pend_in_code;
        next_pend_in_pol   = pend_in_pol;
        next_pend_out_code = pend_out_code;
        next_pend_out_pol  = pend_out_pol;
        next_act_in_code   = act_in_code;
        next_act_in_pol    = act_in_pol;
        next_act_out_code  = act_out_code;
        next_act_out_pol   = act_out_pol;
        next_xint_en       = xint_en;
        next_spd_thr       = spd_thr;
        next_int_mask      = int_mask;
        next_int_stat      = int_stat;
        next_ack           = req & ~ack;
        next_rdata         = rdata;
        if (wr_go) begin
            for (int i = 0; i < N_IN; i++) begin
                if (ofs == `DTFM_OFS_IN_FUNC + 8'(4 * i)) begin
                    next_pend_in_code[i] = avs_writedata[CW-1:0];
                    next_pend_in_pol[i]  = avs_writedata[`DTFM_POL_BIT];
                end
            end
            for (int k = 0; k < NO; k++) begin
                if (ofs == `DTFM_OFS_OUT_FUNC + 8'(4 * k)) begin
                    next_pend_out_code[k] = avs_writedata[OW-1:0];
                    next_pend_out_pol[k]  = avs_writedata[`DTFM_POL_BIT];
                end
            end
            if (ofs == `DTFM_OFS_CTRL) begin
                next_xint_en = avs_writedata[`DTFM_CTRL_XIE_BIT];
            end
            if (ofs == `DTFM_OFS_SPD_THR) begin
                next_spd_thr = avs_writedata[15:0];
            end
            if (ofs == `DTFM_OFS_INT_MASK) begin
                next_int_mask = avs_writedata[NEV-1:0];
            end
            if (ofs == `DTFM_OFS_INT_STAT) begin
                next_int_stat = int_stat & ~avs_writedata[NEV-1:0];
            end
        end
        // a new event wins over a clear in the same cycle
        next_int_stat = next_int_stat | ev;
        // only the power-up event moves pending settings into use
        if (power_up_latch) begin
            next_act_in_code  = pend_in_code;
            next_act_in_pol   = pend_in_pol;
            next_act_out_code = pend_out_code;
            next_act_out_pol  = pend_out_pol;
        end
        // read data sampled in the wait cycle, stands in the answer cycle
        if (avs_read && !ack) begin
            next_rdata = '0;
            for (int i = 0; i < N_IN; i++) begin
                if (ofs == `DTFM_OFS_IN_FUNC + 8'(4 * i)) begin
                    next_rdata[CW-1:0]         = pend_in_code[i];
                    next_rdata[`DTFM_POL_BIT]  = pend_in_pol[i];
                end
            end
            for (int k = 0; k < NO; k++) begin
                if (ofs == `DTFM_OFS_OUT_FUNC + 8'(4 * k)) begin
                    next_rdata[OW-1:0]         = pend_out_code[k];
                    next_rdata[`DTFM_POL_BIT]  = pend_out_pol[k];
                end
            end
            case (ofs)
                `DTFM_OFS_CTRL: begin
                    next_rdata[`DTFM_CTRL_XIE_BIT] = xint_en;
                end
                `DTFM_OFS_SPD_THR: begin
                    next_rdata[15:0] = spd_thr;
                end
                `DTFM_OFS_STATE: begin
                    next_rdata[N_IN-1:0]  = term_act;
                    next_rdata[8]         = armed;
                    next_rdata[9]         = lvl[`DTFM_FN_HOLD];
                    next_rdata[16+NO-1:16] = outs;
                end
                `DTFM_OFS_INT_STAT: begin
                    next_rdata[NEV-1:0] = int_stat;
                end
                `DTFM_OFS_INT_MASK: begin
                    next_rdata[NEV-1:0] = int_mask;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < N_IN; i++) begin
                pend_in_code[i] <= `DTFM_IN_CODE_RST;
                act_in_code[i]  <= `DTFM_IN_CODE_RST;
            end
            pend_in_pol <= {N_IN{`DTFM_IN_POL_RST}};
            act_in_pol  <= {N_IN{`DTFM_IN_POL_RST}};
            pend_out_code[0] <= `DTFM_OUT1_CODE_RST;
            pend_out_code[1] <= `DTFM_OUT2_CODE_RST;
            pend_out_code[2] <= `DTFM_OUT3_CODE_RST;
            pend_out_code[3] <= `DTFM_OUT4_CODE_RST;
            pend_out_code[4] <= `DTFM_ALM_CODE_RST;
            act_out_code[0]  <= `DTFM_OUT1_CODE_RST;
            act_out_code[1]  <= `DTFM_OUT2_CODE_RST;
            act_out_code[2]  <= `DTFM_OUT3_CODE_RST;
            act_out_code[3]  <= `DTFM_OUT4_CODE_RST;
            act_out_code[4]  <= `DTFM_ALM_CODE_RST;
            pend_out_pol <= {NO{`DTFM_OUT_POL_RST}};
            act_out_pol  <= {NO{`DTFM_OUT_POL_RST}};
            xint_en  <= 1'b0;
            spd_thr  <= `DTFM_SPD_THR_RST;
            int_stat <= '0;
            int_mask <= '0;
            ack      <= 1'b0;
            rdata    <= '0;
        end else if (ce) begin
            pend_in_code  <= next_pend_in_code;
            pend_in_pol   <= next_pend_in_pol;
            pend_out_code <= next_pend_out_code;
            pend_out_pol  <= next_pend_out_pol;
            act_in_code   <= next_act_in_code;
            act_in_pol    <= next_act_in_pol;
            act_out_code  <= next_act_out_code;
            act_out_pol   <= next_act_out_pol;
            xint_en       <= next_xint_en;
            spd_thr       <= next_spd_thr;
            int_stat      <= next_int_stat;
            int_mask      <= next_int_mask;
            ack           <= next_ack;
            rdata         <= next_rdata;
        end
    end

    assign avs_readdata = rdata;

endmodule // dtfm_terminal_map

// [sim/dtfm_terminal_map_monitor.sv]
`timescale 1ns/1ps
module dtfm_terminal_map_monitor
    import dtfm_pkg::*;
#(
    parameter int N_IN  = 8,
    parameter int N_OUT = 4
) (
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire logic                   ce,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic                   avs_waitrequest,
    input wire logic                   power_up_latch,
    input wire dtfm_pkg::dtfm_status_t drive_status,
    input wire dtfm_pkg::dtfm_cmd_t    drive_cmd,
    input wire logic [N_OUT-1:0]       general_output,
    input wire logic                   alarm_output,
    input wire logic                   irq
);
    import dtfm_pkg::*;
    // reset map holds until the first power-up latch
    logic dflt;
    logic next_dflt;
    always_comb begin
        next_dflt = dflt;
        if (!resetn) next_dflt = 1'b1;
        else if (ce && power_up_latch) next_dflt = 1'b0;
    end
    always_ff @(posedge clk) begin
        dflt <= next_dflt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_map;
        dflt && ce && !power_up_latch;
    endsequence
    property p_rst;
        disable iff (1'b0)
        !resetn |=> drive_cmd == '0 && general_output == '0 && !alarm_output && !irq;
    endproperty
    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest;
    endproperty
    property p_wait_idle;
        !(avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    property p_home_pulse;
        drive_cmd.home_search_trigger |=> !drive_cmd.home_search_trigger;
    endproperty
    property p_origin_pulse;
        $rose(drive_cmd.origin_marker) |=> $fell(drive_cmd.origin_marker);
    endproperty
    property p_ready;
        s_map |=> general_output[0] == ($past(drive_status.ready) && !$past(drive_status.fault));
    endproperty
    property p_on;
        s_map |=> general_output[1] == $past(drive_status.energised);
    endproperty
    property p_spd;
        s_map |=> general_output[2] == $past(drive_status.speed_reached);
    endproperty
    property p_pos;
        s_map |=> general_output[3] == $past(drive_status.position_done);
    endproperty
    property p_alm;
        s_map |=> alarm_output == $past(drive_status.fault);
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    a_wait_one: assert property (p_wait_one) else $error("wait too long");
    a_wait_idle: assert property (p_wait_idle) else $error("idle wait");
    a_home_pulse: assert property (p_home_pulse) else $error("home pulse long");
    a_origin_pulse: assert property (p_origin_pulse) else $error("origin pulse");
    a_ready: assert property (p_ready) else $error("ready output");
    a_on: assert property (p_on) else $error("energised output");
    a_spd: assert property (p_spd) else $error("speed output");
    a_pos: assert property (p_pos) else $error("position output");
    a_alm: assert property (p_alm) else $error("alarm output");
    c_rd: cover property (avs_read && !avs_waitrequest);
    c_home: cover property (drive_cmd.home_search_trigger);
    c_store: cover property (drive_cmd.stored_move_trigger);
    c_irq: cover property (irq);
endmodule // dtfm_terminal_map_monitor

bind dtfm_terminal_map dtfm_terminal_map_monitor #(.N_IN(N_IN), .N_OUT(N_OUT)) u_mon (
    .clk, .resetn, .ce, .avs_read, .avs_write, .avs_waitrequest, .power_up_latch,
    .drive_status, .drive_cmd, .general_output, .alarm_output, .irq);

// [sim/dtfm_switch_bank.sv]
`timescale 1ns/1ps
// high = contact closed; slow mode lags each change by three extra cycles
module dtfm_switch_bank #(
    parameter int N = 8
) (
    input wire logic         clk,
    input wire logic [N-1:0] level,
    input wire logic         slow,
    output logic [N-1:0]     pin
);
    int lag = 0;
    initial pin = '0;
    always @(posedge clk) begin
        if (pin != level && slow && lag < 3) begin
            lag <= lag + 1;
        end else begin
            pin <= level;
            lag <= 0;
        end
    end
endmodule // dtfm_switch_bank

// [sim/drive_terminal_function_map_test.sv]
`timescale 1ns/1ps
`include "dtfm_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module drive_terminal_function_map_test;
    import dtfm_pkg::*;
    logic          clk = 0, resetn = 0, ce = 1, latch = 0, slow = 0, wt, fault_out, irq, pol;
    dtfm_avm_req_t rq = '0;
    dtfm_status_t  st = '0, so;
    dtfm_cmd_t     cmd, exp;
    logic [31:0]   rdata, d;
    logic [3:0]    gout;
    logic [7:0]    lvl = '0, pin, ina, act;
    int            errors = 0, compares = 0, seed = 89, cyc = 0, cnt[13], b;
    int            oc[5] = '{0, 1, 3, 4, 6};
    bit            edg;
    always #12.5 clk = ~clk;
    dtfm_terminal_map dut (
        .clk(clk), .resetn(resetn), .ce(ce), .avs_read(rq.read), .avs_write(rq.write),
        .avs_address(rq.address), .avs_writedata(rq.writedata), .avs_readdata(rdata),
        .avs_waitrequest(wt), .terminal_pin(pin), .power_up_latch(latch),
        .drive_status(st), .drive_cmd(cmd), .general_output(gout), .alarm_output(fault_out),
        .irq(irq));
    dtfm_switch_bank sw (.clk(clk), .level(lvl), .slow(slow), .pin(pin));
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            summarize();
        end
    end
    task summarize;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
        @(posedge clk);
        rq <= '{read: !w, write: w, address: a, writedata: v};
        // waitrequest and read data are taken at the rising edge only
        do @(posedge clk); while (wt);
        r = rdata;
        rq <= '0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v, d);
    endtask
    function automatic dtfm_status_t rnd();
        logic [31:0]  r;
        dtfm_status_t s;
        r = $random(seed);
        s = r[28:0];
        s.speed = 16'($random(seed) % 32);
        return s;
    endfunction
    function automatic logic fexp(int c, dtfm_status_t s);
        int sp;
        sp = $signed(s.speed);
        case (c)
            0: return s.ready & ~s.fault;
            1: return s.energised;
            2: return (sp < 0 ? -sp : sp) > int'(`DTFM_SPD_THR_RST);
            3: return s.speed_reached;
            4: return s.position_done;
            5: return s.torque_limited;
            6: return s.fault;
            7: return s.brake;
            8: return s.overload_warn;
            9: return s.speed_limited;
            10: return s.stored_move_active;
            11: return s.deviation_excess;
            12: return s.homing_done;
            14: return s.cam_active;
            default: return 1'b0;
        endcase
    endfunction
    task chk_out;
        @(posedge clk);
        st <= rnd();
        repeat (2) @(posedge clk);
        #1;
        for (int k = 0; k < 4; k++) `CHK(gout[k], fexp(oc[k], st))
        `CHK(fault_out, fexp(oc[4], st))
    endtask
    task latch_map;
        @(posedge clk);
        latch <= 1'b1;
        @(posedge clk);
        latch <= 1'b0;
    endtask
    // 12 cycles cover sync, filter and a slow contact
    task settle(input logic [7:0] v);
        @(posedge clk);
        lvl <= v;
        slow <= $random(seed);
        cnt = '{default: 0};
        repeat (12) begin
            @(posedge clk);
            #1;
            for (int i = 0; i < 13; i++) cnt[i] += int'(cmd[i]);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        bus(1'b0, `DTFM_OFS_IN_FUNC, 0, d);
        `CHK(d, 32'h13F)
        for (int k = 0; k < 5; k++) begin
            bus(1'b0, 8'(`DTFM_OFS_OUT_FUNC + 4 * k), 0, d);
            `CHK(d, 32'h100 | oc[k])
        end
        bus(1'b0, `DTFM_OFS_SPD_THR, 0, d);
        `CHK(d, 32'h14)
        bus(1'b0, 8'hFC, 0, d);
        `CHK(d, 32'h0)
        repeat (10) chk_out();
        // clock enable low must freeze the outputs on the old status
        so = st;
        @(posedge clk);
        ce <= 1'b0;
        st <= rnd();
        repeat (3) @(posedge clk);
        #1;
        for (int k = 0; k < 4; k++) `CHK(gout[k], fexp(oc[k], so))
        `CHK(fault_out, fexp(oc[4], so))
        @(posedge clk);
        ce <= 1'b1;
        chk_out();
        $display("test defaults done");
        for (int c = 0; c < 15; c++) begin
            wr(`DTFM_OFS_OUT_FUNC, 32'h100 | c);
            chk_out();
            latch_map();
            oc[0] = c;
            chk_out();
        end
        $display("test output codes done");
        wr(8'h04, 32'h11E);
        for (int c = 19; c <= 33; c++) begin
            pol = $random(seed);
            ina = {7'h0, ~pol};
            act = {7'h0, pol};
            // bit of the command struct: codes 19..28 map to 12..3, 31..33 to 2..0
            b = c == 29 ? 11 : c <= 28 ? 31 - c : 33 - c;
            edg = (c >= 20 && c <= 22) || c == 29;
            wr(`DTFM_OFS_IN_FUNC, {23'h0, pol, 2'b00, 6'(c)});
            settle(ina);
            latch_map();
            settle(ina);
            settle(act);
            exp = '0;
            if (!edg && c != 30) exp[b] = 1'b1;
            `CHK(cmd, exp)
            if (edg) `CHK(cnt[b], (c == 29) ? 0 : 1)
            settle(ina);
            `CHK(cmd, 13'h0)
            if (edg) `CHK(cnt[b], 0)
            if (c == 29) begin
                wr(`DTFM_OFS_CTRL, 32'h1);
                settle(act);
                `CHK(cnt[11], 1)
                bus(1'b0, `DTFM_OFS_STATE, 0, d);
                `CHK(d[9:0], 10'h001)
                settle(ina);
                settle(act);
                `CHK(cnt[11], 0)
                settle(ina);
                settle(ina | 8'h02);
                settle(ina);
                settle(act);
                `CHK(cnt[11], 1)
                settle(ina);
                wr(`DTFM_OFS_CTRL, 32'h0);
            end
        end
        $display("test input codes done");
        bus(1'b0, `DTFM_OFS_INT_STAT, 0, d);
        `CHK(d[3:0], 4'hF)
        wr(`DTFM_OFS_INT_MASK, 32'h0);
        #1;
        `CHK(irq, 1'b0)
        wr(`DTFM_OFS_INT_MASK, 32'h2);
        #1;
        `CHK(irq, 1'b1)
        wr(`DTFM_OFS_INT_STAT, 32'h2);
        #1;
        `CHK(irq, 1'b0)
        bus(1'b0, `DTFM_OFS_INT_STAT, 0, d);
        `CHK(d[1:0], 2'b01)
        $display("test interrupts done");
        summarize();
    end
endmodule // drive_terminal_function_map_test
